// [src/shp_defines.svh]
// Timing, framing and sizing constants for the serial host port.
// Assumes a 20 MHz core clock; included by bare name.
`ifndef SHP_DEFINES_SVH
`define SHP_DEFINES_SVH
// Core clock rate in Hz
`define SHP_CLK_HZ 20000000
// Highest bit rate in bit/s
`define SHP_BAUD_MAX 2000000
// Cycles per bit at the highest rate
`define SHP_BIT_CYCLES (`SHP_CLK_HZ / `SHP_BAUD_MAX)
// Fixed framing: data bits and stop bits
`define SHP_DATA_BITS 8
`define SHP_STOP_BITS 1
// Receive buffer and transmit buffer depths in bytes
`define SHP_RX_DEPTH 1024
`define SHP_TX_DEPTH 16
// Start-up latency in ms, and in core cycles
`define SHP_STARTUP_MS 1600
`define SHP_STARTUP_CYCLES ((`SHP_CLK_HZ / 1000) * `SHP_STARTUP_MS)
// Low time on the receive line, in bit times, that counts as break
`define SHP_BREAK_BITS 20
// Free slots kept when request-to-send drops, for bytes in flight
`define SHP_RTS_MARGIN 8
// Cycles into start-up at which the strap is caught
`define SHP_STRAP_SETTLE 3
`endif

// [src/shp_pkg.sv]
// Types for the serial host port; engine states shared by both ends, start-up states by the device end only.
// Assumes nothing of its surroundings.
package shp_pkg;
  // Character engine states
  typedef enum logic [1:0] {
    SHP_UART_IDLE  = 2'b00,
    SHP_UART_START = 2'b01,
    SHP_UART_DATA  = 2'b10,
    SHP_UART_STOP  = 2'b11
  } shp_uart_st_t;
  // Device start-up states
  typedef enum logic {
    SHP_BOOT_WAIT = 1'b0,
    SHP_BOOT_RUN  = 1'b1
  } shp_boot_st_t;
endpackage

// [src/shp_link_if.sv]
// Wires between the device end and the bridge end of the serial port.
// Assumes both ends run on one core clock; resolves shared pins here.
`timescale 1ns/1ps
interface shp_link_if;
  logic dev_txd; // Device transmit data, idle high
  logic dev_rts_n; // Device request-to-send, low asserted
  logic host_txd; // Bridge transmit data, idle high
  logic host_rts_n; // Bridge request-to-send, device clear-to-send
  logic dtr_o; // Bridge level for the strap
  logic dtr_oe; // Bridge drives the strap
  logic aux_a_o; // Device level on first aux line
  logic aux_a_oe; // Device drives first aux line
  logic aux_b_o; // Device level on second aux line
  logic aux_b_oe; // Device drives second aux line
  logic mode_select_n; // Resolved strap level
  logic aux_line_a; // Resolved first aux line
  logic aux_line_b; // Resolved second aux line
  // Undriven strap rests low, so autorun is the default
  assign mode_select_n = dtr_oe ? dtr_o : 1'b0;
  // Aux lines float high through pull-ups
  assign aux_line_a = aux_a_oe ? aux_a_o : 1'b1;
  assign aux_line_b = aux_b_oe ? aux_b_o : 1'b1;
  modport dev (
    output dev_txd, dev_rts_n, aux_a_o, aux_a_oe, aux_b_o, aux_b_oe,
    input host_txd, host_rts_n, mode_select_n, aux_line_a, aux_line_b
  );
  modport host (
    output host_txd, host_rts_n, dtr_o, dtr_oe,
    input dev_txd, dev_rts_n, aux_line_a, aux_line_b
  );
endinterface

// [src/shp_dev_end.sv]
// Device end of the serial port: buffers, 8N1 engines, strap, break reset.
// Assumes the bridge end on the same clock, joined via shp_link_if.
`timescale 1ns/1ps
`include "shp_defines.svh"

// Valid/ready FIFO; read data is the word at the head
module shp_fifo import shp_pkg::*; #(
  parameter int DATA_W = 8,
  parameter int DEPTH = `SHP_TX_DEPTH
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  input wire logic [DATA_W-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [DATA_W-1:0] o_out_data,
  input wire logic i_out_ready,
  output logic [$clog2(DEPTH+1)-1:0] o_count
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  logic [DATA_W-1:0] mem [DEPTH]; // Storage
  logic [AW-1:0] wr_reg, rd_reg; // Pointers
  logic [CW-1:0] count_reg, count_next; // Fill level
  logic in_ready_reg, out_valid_reg; // Registered flags
  wire push = i_in_valid & in_ready_reg;
  wire pop = out_valid_reg & i_out_ready;
  // Wrap a pointer at the depth
  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction
  // Next fill level
  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end
  // Pointers and flags; flags registered so ports come from flops
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      count_reg <= '0;
      in_ready_reg <= 1'b0;
      out_valid_reg <= 1'b0;
    end else begin
      if (push) wr_reg <= ptr_inc(wr_reg);
      if (pop) rd_reg <= ptr_inc(rd_reg);
      count_reg <= count_next;
      in_ready_reg <= (count_next != CW'(DEPTH));
      out_valid_reg <= (count_next != '0);
    end
  end
  // Storage write, no reset needed
  always_ff @(posedge i_core_clk) begin
    if (push) mem[wr_reg] <= i_in_data;
  end
  assign o_in_ready = in_ready_reg;
  assign o_out_valid = out_valid_reg;
  assign o_out_data = mem[rd_reg];
  assign o_count = count_reg;
endmodule

// 8N1 transmitter; one character per accepted request
module shp_uart_tx import shp_pkg::*; #(
  parameter int BIT_CYCLES = `SHP_BIT_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_valid,
  input wire logic [7:0] i_data,
  output logic o_ready,
  output logic o_txd
);
  shp_uart_st_t st_reg; // Frame phase
  logic [15:0] cnt_reg; // Bit timer
  logic [2:0] bit_reg; // Data bit index
  logic [7:0] sh_reg; // Shift register, LSB first
  logic txd_reg; // Line level
  wire bit_end = (cnt_reg == 16'(BIT_CYCLES - 1));
  // Frame sequencer: start, eight data, one stop, no parity
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      st_reg <= SHP_UART_IDLE;
      cnt_reg <= '0;
      bit_reg <= '0;
      sh_reg <= '0;
      txd_reg <= 1'b1;
    end else begin
      cnt_reg <= bit_end ? '0 : cnt_reg + 1'b1;
      case (st_reg)
        SHP_UART_IDLE: begin
          cnt_reg <= '0;
          txd_reg <= 1'b1;
          if (i_valid) begin
            sh_reg <= i_data;
            txd_reg <= 1'b0;
            st_reg <= SHP_UART_START;
          end
        end
        SHP_UART_START: if (bit_end) begin
          txd_reg <= sh_reg[0];
          bit_reg <= '0;
          st_reg <= SHP_UART_DATA;
        end
        SHP_UART_DATA: if (bit_end) begin
          if (bit_reg == 3'(`SHP_DATA_BITS - 1)) begin
            txd_reg <= 1'b1;
            st_reg <= SHP_UART_STOP;
          end else begin
            txd_reg <= sh_reg[bit_reg + 1'b1];
            bit_reg <= bit_reg + 1'b1;
          end
        end
        SHP_UART_STOP: if (bit_end) st_reg <= SHP_UART_IDLE;
        default: st_reg <= SHP_UART_IDLE;
      endcase
    end
  end
  assign o_ready = (st_reg == SHP_UART_IDLE);
  assign o_txd = txd_reg;
endmodule

// 8N1 receiver; input must already be synchronised
module shp_uart_rx import shp_pkg::*; #(
  parameter int BIT_CYCLES = `SHP_BIT_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_rxd,
  output logic o_valid,
  output logic [7:0] o_data
);
  shp_uart_st_t st_reg; // Frame phase
  logic [15:0] cnt_reg; // Bit timer
  logic [2:0] bit_reg; // Data bit index
  logic [7:0] sh_reg; // Assembled byte
  logic valid_reg; // Good frame pulse
  wire bit_end = (cnt_reg == 16'(BIT_CYCLES - 1));
  wire half_end = (cnt_reg == 16'(BIT_CYCLES / 2 - 1));
  // Sample mid-bit; a bad stop bit drops the byte
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      st_reg <= SHP_UART_IDLE;
      cnt_reg <= '0;
      bit_reg <= '0;
      sh_reg <= '0;
      valid_reg <= 1'b0;
    end else begin
      valid_reg <= 1'b0;
      cnt_reg <= bit_end ? '0 : cnt_reg + 1'b1;
      case (st_reg)
        SHP_UART_IDLE: begin
          cnt_reg <= '0;
          if (!i_rxd) st_reg <= SHP_UART_START;
        end
        SHP_UART_START: if (half_end) begin
          // Glitch shorter than half a bit is ignored
          cnt_reg <= '0;
          bit_reg <= '0;
          st_reg <= i_rxd ? SHP_UART_IDLE : SHP_UART_DATA;
        end
        SHP_UART_DATA: if (bit_end) begin
          sh_reg <= {i_rxd, sh_reg[7:1]};
          bit_reg <= bit_reg + 1'b1;
          if (bit_reg == 3'(`SHP_DATA_BITS - 1)) st_reg <= SHP_UART_STOP;
        end
        SHP_UART_STOP: if (bit_end) begin
          valid_reg <= i_rxd;
          st_reg <= SHP_UART_IDLE;
        end
        default: st_reg <= SHP_UART_IDLE;
      endcase
    end
  end
  assign o_valid = valid_reg;
  assign o_data = sh_reg;
endmodule

module shp_dev_end import shp_pkg::*; #(
  parameter int BIT_CYCLES = `SHP_BIT_CYCLES,
  parameter int unsigned STARTUP_CYCLES = `SHP_STARTUP_CYCLES,
  parameter int RX_DEPTH = `SHP_RX_DEPTH,
  parameter int TX_DEPTH = `SHP_TX_DEPTH
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  shp_link_if.dev link,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_ready,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  input wire logic i_rx_ready,
  input wire logic i_script_present,
  input wire logic i_run_cmd,
  input wire logic i_sw_reset,
  input wire logic i_uart_closed,
  input wire logic i_led_on,
  input wire logic [1:0] i_aux_oe,
  input wire logic [1:0] i_aux_level,
  output logic [1:0] o_aux_in,
  output logic o_ready,
  output logic o_mode_autorun,
  output logic o_autorun_start,
  output logic o_run_script,
  output logic o_led_drive
);
  localparam int RCW = $clog2(RX_DEPTH + 1);
  localparam logic [15:0] BREAK_CYC = 16'(BIT_CYCLES * `SHP_BREAK_BITS);
  // Two-stage synchronisers for pins from the bridge side
  logic [1:0] rx_s, cts_s, strap_s, aux_a_s, aux_b_s;
  logic brk_rst_reg; // One-cycle break reset
  logic [15:0] brk_cnt_reg; // Low-time counter
  wire core_rst = i_rst | brk_rst_reg;
  wire boot_rst = core_rst | i_sw_reset;
  shp_boot_st_t boot_reg; // Start-up phase
  logic [31:0] boot_cnt_reg; // Start-up timer
  logic autorun_reg, start_reg, run_reg, led_reg; // Mode and pulses
  logic rts_n_reg; // Request-to-send flop
  logic [1:0] aux_oe_reg, aux_o_reg, aux_in_reg; // Aux pin flops
  wire rx_valid, txf_valid, tx_ready, tx_line;
  wire [7:0] rx_byte, txf_data;
  wire [RCW-1:0] rx_count;
  // Synchronisers; only the second stage is read
  always_ff @(posedge i_core_clk) begin
    rx_s <= {rx_s[0], link.host_txd};
    cts_s <= {cts_s[0], link.host_rts_n};
    strap_s <= {strap_s[0], link.mode_select_n};
    aux_a_s <= {aux_a_s[0], link.aux_line_a};
    aux_b_s <= {aux_b_s[0], link.aux_line_b};
  end
  // Break detector; fires once per break, blocked by a closed port in autorun mode only
  wire brk_allowed = ~(autorun_reg & i_uart_closed);
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      brk_cnt_reg <= '0;
      brk_rst_reg <= 1'b0;
    end else begin
      brk_rst_reg <= 1'b0;
      if (rx_s[1]) begin
        brk_cnt_reg <= '0;
      end else if (brk_cnt_reg != BREAK_CYC) begin
        brk_cnt_reg <= brk_cnt_reg + 1'b1;
        brk_rst_reg <= (brk_cnt_reg == BREAK_CYC - 1'b1) & brk_allowed;
      end
    end
  end
  // Start-up: strap caught once early, ready after the long wait
  always_ff @(posedge i_core_clk) begin
    if (boot_rst) begin
      boot_reg <= SHP_BOOT_WAIT;
      boot_cnt_reg <= '0;
      start_reg <= 1'b0;
      run_reg <= 1'b0;
      autorun_reg <= 1'b1; // Autorun until the strap is caught
    end else begin
      start_reg <= 1'b0;
      run_reg <= 1'b0;
      case (boot_reg)
        SHP_BOOT_WAIT: begin
          boot_cnt_reg <= boot_cnt_reg + 1'b1;
          if (boot_cnt_reg == 32'(`SHP_STRAP_SETTLE)) autorun_reg <= ~strap_s[1];
          if (boot_cnt_reg == STARTUP_CYCLES - 1) begin
            boot_reg <= SHP_BOOT_RUN;
            start_reg <= autorun_reg & i_script_present;
          end
        end
        // Strap no longer looked at until next reset
        SHP_BOOT_RUN: run_reg <= ~autorun_reg & i_run_cmd;
        default: boot_reg <= SHP_BOOT_WAIT;
      endcase
    end
  end
  // Receive buffer, flow control and pins
  always_ff @(posedge i_core_clk) begin
    if (core_rst) begin
      rts_n_reg <= 1'b1;
      led_reg <= 1'b0;
      aux_oe_reg <= 2'b00;
      aux_o_reg <= 2'b11;
      aux_in_reg <= 2'b11;
    end else begin
      rts_n_reg <= ~(rx_count < RCW'(RX_DEPTH - `SHP_RTS_MARGIN));
      led_reg <= i_led_on;
      aux_oe_reg <= i_aux_oe;
      aux_o_reg <= i_aux_level;
      aux_in_reg <= {aux_b_s[1], aux_a_s[1]};
    end
  end
  shp_uart_rx #(.BIT_CYCLES(BIT_CYCLES)) u_rx (
    .i_core_clk(i_core_clk), .i_rst(core_rst), .i_rxd(rx_s[1]),
    .o_valid(rx_valid), .o_data(rx_byte)
  );
  shp_fifo #(.DATA_W(8), .DEPTH(RX_DEPTH)) u_rx_buf (
    .i_core_clk(i_core_clk), .i_rst(core_rst),
    .i_in_valid(rx_valid), .i_in_data(rx_byte), .o_in_ready(),
    .o_out_valid(o_rx_valid), .o_out_data(o_rx_data),
    .i_out_ready(i_rx_ready), .o_count(rx_count)
  );
  shp_fifo #(.DATA_W(8), .DEPTH(TX_DEPTH)) u_tx_buf (
    .i_core_clk(i_core_clk), .i_rst(core_rst),
    .i_in_valid(i_tx_valid), .i_in_data(i_tx_data), .o_in_ready(o_tx_ready),
    .o_out_valid(txf_valid), .o_out_data(txf_data),
    .i_out_ready(tx_ready & ~cts_s[1]), .o_count()
  );
  // Clear-to-send checked only between characters
  shp_uart_tx #(.BIT_CYCLES(BIT_CYCLES)) u_tx (
    .i_core_clk(i_core_clk), .i_rst(core_rst),
    .i_valid(txf_valid & ~cts_s[1]), .i_data(txf_data),
    .o_ready(tx_ready), .o_txd(tx_line)
  );
  assign link.dev_txd = tx_line;
  assign link.dev_rts_n = rts_n_reg;
  assign link.aux_a_oe = aux_oe_reg[0];
  assign link.aux_b_oe = aux_oe_reg[1];
  assign link.aux_a_o = aux_o_reg[0];
  assign link.aux_b_o = aux_o_reg[1];
  assign o_aux_in = aux_in_reg;
  assign o_ready = (boot_reg == SHP_BOOT_RUN);
  assign o_mode_autorun = autorun_reg;
  assign o_autorun_start = start_reg;
  assign o_run_script = run_reg;
  assign o_led_drive = led_reg;
endmodule

// [src/shp_host_end.sv]
// Bridge end of the serial port: 8N1 engines, handshake, strap, break.
// Assumes shp_dev_end.sv is compiled first for the character engines.
`timescale 1ns/1ps
`include "shp_defines.svh"
module shp_host_end import shp_pkg::*; #(
  parameter int BIT_CYCLES = `SHP_BIT_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  shp_link_if.host link,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_ready,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  input wire logic i_rx_ready,
  input wire logic i_dtr_oe,
  input wire logic i_dtr_level,
  input wire logic i_send_break,
  output logic [1:0] o_aux_in
);
  logic [1:0] rx_s, rts_s, aux_a_s, aux_b_s; // Synchronisers
  logic ready_reg, line_reg, rts_n_reg, dtr_o_reg, dtr_oe_reg;
  logic rxv_reg; // Received byte pulse
  logic [7:0] rxd_reg; // Received byte
  logic [1:0] aux_reg; // Aux levels seen
  wire tx_idle, tx_line, rx_valid;
  wire [7:0] rx_byte;
  // Send only while the device asks for data and no break is held
  wire take = i_tx_valid & ready_reg;
  wire ready_next = tx_idle & ~rts_s[1] & ~i_send_break & ~take;
  // Synchronisers; only the second stage is read
  always_ff @(posedge i_core_clk) begin
    rx_s <= {rx_s[0], link.dev_txd};
    rts_s <= {rts_s[0], link.dev_rts_n};
    aux_a_s <= {aux_a_s[0], link.aux_line_a};
    aux_b_s <= {aux_b_s[0], link.aux_line_b};
  end
  // Output flops: line, handshake, strap drive, received byte
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ready_reg <= 1'b0;
      line_reg <= 1'b1;
      rts_n_reg <= 1'b1;
      dtr_o_reg <= 1'b0;
      dtr_oe_reg <= 1'b0;
      rxv_reg <= 1'b0;
      rxd_reg <= '0;
      aux_reg <= 2'b11;
    end else begin
      ready_reg <= ready_next;
      // Break holds the line low for as long as asked
      line_reg <= tx_line & ~i_send_break;
      rts_n_reg <= ~i_rx_ready;
      dtr_o_reg <= i_dtr_level;
      dtr_oe_reg <= i_dtr_oe;
      rxv_reg <= rx_valid;
      if (rx_valid) rxd_reg <= rx_byte;
      aux_reg <= {aux_b_s[1], aux_a_s[1]};
    end
  end
  shp_uart_tx #(.BIT_CYCLES(BIT_CYCLES)) u_tx (
    .i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_valid(take), .i_data(i_tx_data),
    .o_ready(tx_idle), .o_txd(tx_line)
  );
  shp_uart_rx #(.BIT_CYCLES(BIT_CYCLES)) u_rx (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_rxd(rx_s[1]),
    .o_valid(rx_valid), .o_data(rx_byte)
  );
  assign link.host_txd = line_reg;
  assign link.host_rts_n = rts_n_reg;
  assign link.dtr_o = dtr_o_reg;
  assign link.dtr_oe = dtr_oe_reg;
  assign o_tx_ready = ready_reg;
  assign o_rx_valid = rxv_reg;
  assign o_rx_data = rxd_reg;
  assign o_aux_in = aux_reg;
endmodule

// [test/shp_link_monitor.sv]
// Checker on the wires between the device end and the bridge end.
// Assumes one core clock, synchronous active-high reset, 10 cycles per bit.
`timescale 1ns/1ps
module shp_link_monitor (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic dev_txd,
  input wire logic dev_rts_n,
  input wire logic host_txd,
  input wire logic host_rts_n,
  input wire logic dtr_oe,
  input wire logic mode_select_n,
  input wire logic aux_a_oe,
  input wire logic aux_b_oe
);
  // One clock domain, so clocking and reset are given once
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  // Falls inside a frame are data bits, so only an idle line can start one
  logic dev_prev, host_prev; // Levels one cycle back
  logic [6:0] dev_busy, host_busy; // Cycles still masked
  wire dev_start = dev_prev & ~dev_txd & (dev_busy == 7'h00);
  wire host_start = host_prev & ~host_txd & (host_busy == 7'h00);
  // Mask 95 cycles after a start, short of the stop bit's end
  always_ff @(posedge i_core_clk) begin
    dev_prev <= i_rst | dev_txd;
    host_prev <= i_rst | host_txd;
    dev_busy <= i_rst ? 7'h00 : (dev_start ? 7'h5f : dev_busy - 7'(dev_busy != 7'h00));
    host_busy <= i_rst ? 7'h00 : (host_start ? 7'h5f : host_busy - 7'(host_busy != 7'h00));
  end

  // Start bit holds low for the eight cycles after its falling edge
  a_dev_start_bit: assert property (dev_start |=> !dev_txd [*8])
    else $error("device start bit cut short");
  // Stop bit is high ninety cycles after the start edge
  a_dev_stop_bit: assert property (dev_start |-> ##90 dev_txd [*8])
    else $error("device stop bit missing");
  // Bridge start bit, or a break, is never a glitch
  a_host_start_bit: assert property (host_start |=> !host_txd [*8])
    else $error("bridge start bit cut short");
  // Data lines and handshakes leave reset at rest
  a_idle_after_reset: assert property ($fell(i_rst) |-> dev_txd && host_txd && dev_rts_n && host_rts_n)
    else $error("line not idle after reset");
  // Empty receive buffer asks for data soon after reset
  a_rts_after_reset: assert property ($fell(i_rst) |-> ##[1:3] !dev_rts_n)
    else $error("request-to-send not asserted");
  // Device starts a character only while clear-to-send was low
  a_dev_waits_cts: assert property (dev_start |->
    !($past(host_rts_n, 2) && $past(host_rts_n, 3) && $past(host_rts_n, 4)))
    else $error("device sent without clear-to-send");
  // Bridge starts a character only while the device asked for data
  a_host_honours_rts: assert property (host_start |->
    !($past(dev_rts_n, 3) && $past(dev_rts_n, 4) && $past(dev_rts_n, 5)))
    else $error("bridge sent against request-to-send");
  // Aux lines are not driven out of reset
  a_aux_undriven: assert property ($fell(i_rst) |-> (!aux_a_oe && !aux_b_oe) [*2])
    else $error("aux line driven after reset");
  // Undriven strap rests low
  a_strap_default: assert property (!dtr_oe |-> !mode_select_n)
    else $error("undriven strap not low");

  // Main traffic and a flow-control stop seen
  c_dev_char: cover property ($fell(dev_txd));
  c_host_char: cover property ($fell(host_txd));
  c_rts_stop: cover property ($rose(dev_rts_n));
endmodule

// [test/shp_tb_top.sv]
// Self-checking bench: both ends joined through the link interface.
// Assumes the design files are compiled first; shortened start-up count.
`timescale 1ns/1ps
module shp_tb_top;
  localparam int BC = 10; // Cycles per bit, top rate
  localparam int SU = 200; // Start-up count kept short for run time
  localparam int RXD = 32; // Small receive buffer so flow control is reachable
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic d_tx_valid, d_tx_ready, d_rx_valid, d_rx_ready, h_tx_valid, h_tx_ready, h_rx_valid, h_rx_ready;
  logic [7:0] d_tx_data, d_rx_data, h_tx_data, h_rx_data;
  logic script, run_cmd, sw_reset, closed, led_on, ready, mode_auto, auto_start, run_script, led;
  logic dtr_oe, dtr_lvl, brk;
  logic [1:0] aux_oe, aux_level, d_aux_in, h_aux_in;
  logic [7:0] dq[$]; // Bytes handed out by the device
  logic [7:0] hq[$]; // Bytes handed out by the bridge
  int mismatches = 0;
  int check_count = 0;

  shp_link_if link();
  shp_dev_end #(.BIT_CYCLES(BC), .STARTUP_CYCLES(SU), .RX_DEPTH(RXD), .TX_DEPTH(16)) i_shp_dev_end (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .link(link), .i_tx_valid(d_tx_valid), .i_tx_data(d_tx_data),
    .o_tx_ready(d_tx_ready), .o_rx_valid(d_rx_valid), .o_rx_data(d_rx_data), .i_rx_ready(d_rx_ready),
    .i_script_present(script), .i_run_cmd(run_cmd), .i_sw_reset(sw_reset), .i_uart_closed(closed),
    .i_led_on(led_on), .i_aux_oe(aux_oe), .i_aux_level(aux_level), .o_aux_in(d_aux_in), .o_ready(ready),
    .o_mode_autorun(mode_auto), .o_autorun_start(auto_start), .o_run_script(run_script), .o_led_drive(led));
  shp_host_end #(.BIT_CYCLES(BC)) i_shp_host_end (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .link(link), .i_tx_valid(h_tx_valid), .i_tx_data(h_tx_data),
    .o_tx_ready(h_tx_ready), .o_rx_valid(h_rx_valid), .o_rx_data(h_rx_data), .i_rx_ready(h_rx_ready),
    .i_dtr_oe(dtr_oe), .i_dtr_level(dtr_lvl), .i_send_break(brk), .o_aux_in(h_aux_in));
  shp_link_monitor i_shp_link_monitor (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .dev_txd(link.dev_txd), .dev_rts_n(link.dev_rts_n),
    .host_txd(link.host_txd), .host_rts_n(link.host_rts_n), .dtr_oe(link.dtr_oe),
    .mode_select_n(link.mode_select_n), .aux_a_oe(link.aux_a_oe), .aux_b_oe(link.aux_b_oe));

  // Free-running core clock, 50 ns
  initial begin
    forever #25 i_core_clk = ~i_core_clk;
  end

  // Collect every byte either end hands to its user
  always @(posedge i_core_clk) begin
    if (d_rx_valid === 1'b1 && d_rx_ready === 1'b1) dq.push_back(d_rx_data);
    if (h_rx_valid === 1'b1) hq.push_back(h_rx_data);
  end

  // Expected mode: undriven strap rests low, low means autorun
  function automatic logic exp_mode(input logic oe, input logic lvl);
    return oe ? ~lvl : 1'b1;
  endfunction
  // Expected aux level: pulled high unless driven
  function automatic logic exp_line(input logic oe, input logic lvl);
    return oe ? lvl : 1'b1;
  endfunction
  // Start-up length, with slack for sync stages
  function automatic logic ok_su(input int n);
    return n >= SU - 8 && n <= SU + 3;
  endfunction

  // Inputs move 1 ns after the edge, never on it
  task automatic tick(input int n = 1);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Bridge push: hold valid and data until ready is seen at an edge
  task automatic hsend(input logic [7:0] b);
    int n;
    n = 0;
    h_tx_data = b;
    h_tx_valid = 1'b1;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (h_tx_ready !== 1'b1 && n < 5000);
    if (n >= 5000) mismatches++;
    #1;
    h_tx_valid = 1'b0;
    tick();
  endtask
  // Device push, same handshake
  task automatic dsend(input logic [7:0] b);
    int n;
    n = 0;
    d_tx_data = b;
    d_tx_valid = 1'b1;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (d_tx_ready !== 1'b1 && n < 5000);
    if (n >= 5000) mismatches++;
    #1;
    d_tx_valid = 1'b0;
    tick();
  endtask
  // Strap level is set up before reset so the catch sees it
  task automatic do_reset(input logic oe, input logic lvl);
    dtr_oe = oe;
    dtr_lvl = lvl;
    i_rst = 1'b1;
    tick(10);
    i_rst = 1'b0;
  endtask
  task automatic wait_ready(output int n, output logic st);
    n = 0;
    st = 1'b0;
    while (ready !== 1'b1 && n < 1000) begin
      tick();
      n++;
      if (auto_start === 1'b1) st = 1'b1;
    end
  endtask
  // Holds a break until the device drops ready, or 300 cycles
  task automatic brk_try(output int m);
    brk = 1'b1;
    m = 0;
    while (ready === 1'b1 && m < 300) begin
      tick();
      m++;
    end
    tick(5);
    brk = 1'b0;
  endtask

  // Hang guard, well beyond the expected run
  initial begin
    repeat (30000) @(posedge i_core_clk);
    mismatches++;
    end_sim();
  end

  initial begin
    int n;
    logic st;
    logic [7:0] b;
    logic [7:0] tx_h[8];
    logic [7:0] tx_d[8];
    logic [7:0] sq[$];
    logic [7:0] fq[$];
    {d_tx_valid, h_tx_valid, run_cmd, sw_reset, closed, led_on, brk} = '0;
    {d_tx_data, h_tx_data, aux_oe, aux_level, dtr_oe, dtr_lvl} = '0;
    {d_rx_ready, h_rx_ready, script} = 3'b111;
    void'($urandom(32'hedb7859b));
    // Undriven strap with a script present: autorun
    do_reset(1'b0, 1'b0);
    wait_ready(n, st);
    chk(ok_su(n), 1'b1);
    chk(st, 1'b1);
    chk(mode_auto, exp_mode(1'b0, 1'b0));
    // Both directions at once, edge values first
    foreach (tx_h[i]) begin
      tx_h[i] = 8'($urandom);
      tx_d[i] = 8'($urandom);
    end
    {tx_h[0], tx_d[0], tx_h[1], tx_d[1]} = 32'h00ff8001;
    fork
      for (int i = 0; i < 8; i++) hsend(tx_h[i]);
      for (int i = 0; i < 8; i++) dsend(tx_d[i]);
    join
    tick(150);
    chk(16'(dq.size() + hq.size()), 16'h0010);
    for (int i = 0; i < 8 && i < dq.size() && i < hq.size(); i++) begin
      chk(dq[i], tx_h[i]);
      chk(hq[i], tx_d[i]);
    end
    dq.delete();
    hq.delete();
    // Stalled consumer: device must ask the bridge to stop
    d_rx_ready = 1'b0;
    fork
      for (int i = 0; i < 28; i++) begin
        b = 8'($urandom);
        sq.push_back(b);
        hsend(b);
      end
      begin
        tick(3000);
        chk(link.dev_rts_n, 1'b1);
        d_rx_ready = 1'b1;
      end
    join
    tick(800);
    chk(16'(dq.size()), 16'(sq.size()));
    for (int i = 0; i < sq.size() && i < dq.size(); i++) chk(dq[i], sq[i]);
    chk(link.dev_rts_n, 1'b0);
    // Strap driven high: interactive, later strap moves ignored
    do_reset(1'b1, 1'b1);
    wait_ready(n, st);
    chk(st, 1'b0);
    chk(mode_auto, exp_mode(1'b1, 1'b1));
    dtr_lvl = 1'b0;
    tick(10);
    chk(mode_auto, exp_mode(1'b1, 1'b1));
    run_cmd = 1'b1;
    tick();
    run_cmd = 1'b0;
    st = run_script;
    repeat (2) begin
      tick();
      st |= run_script;
    end
    chk(st, 1'b1);
    // Break in interactive mode resets even with the port closed
    closed = 1'b1;
    brk_try(n);
    chk(n >= 20 * BC && n <= 20 * BC + 10, 1'b1);
    wait_ready(n, st);
    chk(ok_su(n + 5), 1'b1);
    chk(mode_auto, exp_mode(1'b1, 1'b0));
    // Autorun with the port closed: break has no effect
    brk_try(n);
    chk(n, 300);
    closed = 1'b0;
    // Software reset restarts start-up
    sw_reset = 1'b1;
    tick();
    sw_reset = 1'b0;
    tick(2);
    chk(ready, 1'b0);
    wait_ready(n, st);
    chk(ok_su(n + 3), 1'b1);
    // LED and aux lines, first pass undriven
    for (int i = 0; i < 5; i++) begin
      led_on = 1'($urandom);
      aux_oe = (i == 0) ? 2'b00 : 2'($urandom);
      aux_level = 2'($urandom);
      tick(6);
      chk(led, led_on);
      chk(h_aux_in, {exp_line(aux_oe[1], aux_level[1]), exp_line(aux_oe[0], aux_level[0])});
      chk(d_aux_in, {exp_line(aux_oe[1], aux_level[1]), exp_line(aux_oe[0], aux_level[0])});
    end
    // Transmit buffer held off by clear-to-send: fill until refused, then drain
    h_rx_ready = 1'b0;
    hq.delete();
    tick(4);
    for (int i = 0; i < 16; i++) begin
      d_tx_data = 8'($urandom);
      fq.push_back(d_tx_data);
      d_tx_valid = 1'b1;
      chk(d_tx_ready, 1'b1);
      tick();
    end
    chk(d_tx_ready, 1'b0);
    chk(link.dev_txd, 1'b1);
    tick();
    d_tx_valid = 1'b0;
    h_rx_ready = 1'b1;
    tick(1700);
    chk(16'(hq.size()), 16'h0010);
    for (int i = 0; i < 16 && i < hq.size(); i++) chk(hq[i], fq[i]);
    chk(d_tx_ready, 1'b1);
    chk(link.dev_txd, 1'b1);
    end_sim();
  end
endmodule
